// file: rtl/ids_pkg.sv
// constants, register map and carrier types for the internal data sampler
package ids_pkg;
    // phase codes presented by the timing generator
    localparam logic [1:0] PH_A = 2'h0;
    localparam logic [1:0] PH_B = 2'h1;
    localparam logic [1:0] PH_C = 2'h2;
    // bit-time numbering within a phase
    localparam logic [3:0] BT_1 = 4'h1;
    localparam logic [3:0] BT_2 = 4'h2;
    localparam logic [3:0] BT_8 = 4'h8;
    localparam logic [3:0] BT_14 = 4'hE;
    // register widths
    localparam int PRI_W = 13;
    localparam int SEC_W = 7;
    // primary register field positions
    localparam int LOW_PAIR_BIT = 0;
    localparam int MID_LO = 1;
    localparam int MID_HI = 8;
    localparam int HIGH_LO = 9;
    localparam int HIGH_HI = 12;
    // address decoder group codes
    localparam logic [2:0] SEL_NONE = 3'h0;
    localparam logic [2:0] SEL_CROSSOVER = 3'h1;
    localparam logic [2:0] SEL_ERR_MON = 3'h2;
    localparam logic [2:0] SEL_ICR = 3'h3;
    localparam logic [2:0] SEL_LADDER = 3'h4;
    localparam logic [2:0] SEL_SWITCH_OUT = 3'h5;
    // phase transitions during which a phase-A error holds
    localparam logic [1:0] HOLD_PHASES = 2'h3;
    // register map (byte addresses)
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_INT_STATUS = 8'h04;
    localparam logic [7:0] ADDR_INT_CLEAR = 8'h08;
    localparam logic [7:0] ADDR_INT_ENABLE = 8'h0C;
    localparam logic [7:0] ADDR_STATE = 8'h10;
    localparam logic [7:0] ADDR_SEC_MUX = 8'h14;
    // reset values
    localparam logic [1:0] CTRL_RST = 2'h3;
    localparam logic [2:0] INT_EN_RST = 3'h0;
    // interrupt event bit positions
    localparam int EV_CAPTURE = 0;
    localparam int EV_SEC_SEL = 1;
    localparam int EV_HOLD_END = 2;
    localparam int EV_W = 3;

    // timing strobes from the external generator
    typedef struct packed {
        logic [1:0] phase;
        logic [3:0] bit_time;
        logic w;
        logic x;
        logic y;
        logic z;
    } timing_s;

    // the five selectable signal groups
    typedef struct packed {
        logic [PRI_W-1:0] crossover_error;
        logic [PRI_W-1:0] error_monitor;
        logic [PRI_W-1:0] internal_ctl_reg;
        logic [PRI_W-1:0] ladder_address;
        logic [PRI_W-1:0] switch_out;
    } groups_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT_B = 2'b01,
        ST_HOLD = 2'b10
    } err_state_e;
endpackage

// file: rtl/internal_data_sampler.sv
// internal data sampler: group multiplexer, error capture and serializers
// Operation
// - decoder code picks at most one of five groups for loading
// - primary serial data goes to system sampler when enabled
// - secondary selector sends secondary mux on error, else primary
// - 13-bit primary register shifted out through one serial latch
// - loads: counter in phase A, error signals, groups in B and C
// - clear pulse at bit 2 W of each phase while no error holds
// - capture pulse one bit time sets low/high latches, then blocks
// - capture inhibits all selections but crossover; inhibit low freezes captured latches
// - phase-A error holds middle latches for the next three phases
// - other errors hold from B-1-X of next cycle until A-14
// - serializer restores order of bits kept in the low pair latch
// - primary stream used downstream only in phases B and C
// - counter clear at B-2-W suppressed after an error
// - primary latch loads in sequence, resets at Z, low pair at C-1/2
// - after error primary stream ignored except at C-1
// - 7-bit secondary mux reset then loaded by each capture pulse
// - secondary latch copies primary at Y in B and C, resets at X
// - secondary select high from B-1-X through A-14-Y on error
//
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/1ps
module internal_data_sampler
    import ids_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire timing_s i_timing,
    input wire logic [2:0] i_group_sel,
    input wire logic i_sds_enable,
    input wire groups_s i_groups,
    input wire logic i_instr_count_in,
    input wire logic i_error_sense,
    input wire logic [PRI_W-1:0] i_err_time_sig,
    input wire logic [SEC_W-1:0] i_sec_timing,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    output logic o_telemetry_out,
    output logic o_sds_out,
    output logic o_irq
);

    // timing decode; the generator strobes are taken as synchronous
    wire ph_a = (i_timing.phase == PH_A);
    wire ph_b = (i_timing.phase == PH_B);
    wire ph_c = (i_timing.phase == PH_C);
    wire ph_bc = ph_b | ph_c;
    wire bt1 = (i_timing.bit_time == BT_1);
    wire bt2 = (i_timing.bit_time == BT_2);
    wire bt14 = (i_timing.bit_time == BT_14);
    wire b1x = ph_b & bt1 & i_timing.x;
    wire a14y = ph_a & bt14 & i_timing.y;
    wire a14z = ph_a & bt14 & i_timing.z;

    logic [1:0] ctrl_r;
    logic [2:0] int_status_r;
    logic [2:0] int_enable_r;
    logic [PRI_W-1:0] pri_r;
    logic [SEC_W-1:0] sec_r;
    logic primary_serial_latch_r;
    logic secondary_serial_latch_r;
    logic error_capture_pulse_r;
    logic cap_first_r;
    logic no_error_hold_n_r;
    logic error_select_secondary_r;
    logic error_inhibit_ctl_n_r;
    logic seen_a_r;
    logic [1:0] phase_cnt_r;
    logic [1:0] last_phase_r;
    logic [31:0] rdata_r;
    err_state_e state_r;
    err_state_e state_nxt;

    wire sampler_en = ctrl_r[0];
    wire sds_gate = ctrl_r[1];
    wire phase_step = (i_timing.phase != last_phase_r);

    // group select; control-type codes blocked while errors are captured
    wire cap_block = error_capture_pulse_r | ~error_inhibit_ctl_n_r;
    logic [PRI_W-1:0] group_data;
    always_comb begin
        group_data = '0;
        case (i_group_sel)
            SEL_CROSSOVER: group_data = i_groups.crossover_error;
            SEL_ERR_MON: group_data = cap_block ? '0 : i_groups.error_monitor;
            SEL_ICR: group_data = cap_block ? '0 : i_groups.internal_ctl_reg;
            SEL_LADDER: group_data = cap_block ? '0 : i_groups.ladder_address;
            SEL_SWITCH_OUT: group_data = cap_block ? '0 : i_groups.switch_out;
            default: group_data = '0;
        endcase
    end

    // middle latches may set only while no error holds them
    logic [PRI_W-1:0] set_mask;
    always_comb begin
        set_mask = '1;
        if (!no_error_hold_n_r) begin
            set_mask[MID_HI:MID_LO] = '0;
        end
        // captured low pair and high group stay frozen
        if (error_capture_pulse_r || !error_inhibit_ctl_n_r) begin
            set_mask[LOW_PAIR_BIT] = 1'b0;
            set_mask[HIGH_HI:HIGH_LO] = '0;
        end
    end

    // instruction counter bit lands in register position bit time minus 2
    wire [3:0] ic_idx = i_timing.bit_time - 4'h2;
    logic [PRI_W-1:0] ic_vec;
    always_comb begin
        ic_vec = '0;
        if (i_timing.bit_time >= BT_2 && i_timing.bit_time <= BT_14) begin
            ic_vec[ic_idx] = i_instr_count_in;
        end
    end

    // three load sources of the primary register
    wire [PRI_W-1:0] load_ic = (ph_a & i_timing.x) ? ic_vec : '0;
    wire [PRI_W-1:0] load_grp =
        (ph_bc & i_timing.x & sampler_en) ? group_data : '0;
    wire [PRI_W-1:0] load_err = error_capture_pulse_r ? i_err_time_sig : '0;
    wire [PRI_W-1:0] cap_mask = {{(HIGH_HI-HIGH_LO+1){1'b1}},
        {(MID_HI-MID_LO+1){1'b0}}, 1'b1};
    wire [PRI_W-1:0] pri_set =
        ((load_ic | load_grp) & set_mask) | (load_err & cap_mask);
    // clear at bit 2 W of each phase, suppressed when holding
    wire mux_clear_pulse = bt2 & i_timing.w & no_error_hold_n_r;

    // primary register: clear then OR in the set terms
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pri_r <= '0;
        end else begin
            pri_r <= (mux_clear_pulse ? '0 : pri_r) | pri_set;
        end
    end

    // serial source: bit time n (3..14) shows register bit n-2; in phase C the
    // low pair appears at C-1 and C-2 to restore bit order
    wire low_pair_slot = ph_c & (bt1 | bt2);
    wire pri_bit = low_pair_slot ? pri_r[LOW_PAIR_BIT] :
        (i_timing.bit_time > BT_2 && i_timing.bit_time <= BT_14) ?
        pri_r[ic_idx] : 1'b0;

    // primary latch: loads at W, resets at Z, every phase
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            primary_serial_latch_r <= 1'b0;
        end else if (i_timing.z) begin
            primary_serial_latch_r <= 1'b0;
        end else if (i_timing.w) begin
            primary_serial_latch_r <= pri_bit;
        end
    end

    // capture pulse lasts from the sensed error to the next Z strobe
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            error_capture_pulse_r <= 1'b0;
            cap_first_r <= 1'b0;
        end else begin
            cap_first_r <= i_error_sense & ~error_capture_pulse_r;
            if (i_error_sense) begin
                error_capture_pulse_r <= 1'b1;
            end else if (i_timing.z) begin
                error_capture_pulse_r <= 1'b0;
            end
        end
    end

    // secondary mux: first cycle of the pulse resets, then stores
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sec_r <= '0;
        end else if (cap_first_r) begin
            sec_r <= '0;
        end else if (error_capture_pulse_r) begin
            sec_r <= sec_r | i_sec_timing;
        end
    end

    // error hold sequencer
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (i_error_sense) begin
                    // phase-A error holds at once
                    state_nxt = ph_a ? ST_HOLD : ST_WAIT_B;
                end
            end
            ST_WAIT_B: begin
                // wait past phase A so the counter loads first
                if (b1x && seen_a_r) begin
                    state_nxt = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (a14z && (phase_cnt_r == HOLD_PHASES || seen_a_r)) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // sequencer state, phase counting and derived levels
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_r <= ST_IDLE;
            last_phase_r <= PH_A;
            phase_cnt_r <= 2'h0;
            seen_a_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            last_phase_r <= i_timing.phase;
            if (state_r == ST_IDLE) begin
                phase_cnt_r <= 2'h0;
                seen_a_r <= 1'b0;
            end else begin
                if (phase_step && phase_cnt_r != HOLD_PHASES) begin
                    phase_cnt_r <= phase_cnt_r + 2'h1;
                end
                // a later phase A (not the error's own) was passed
                if (phase_step && ph_a) begin
                    seen_a_r <= 1'b1;
                end
            end
        end
    end

    // hold, inhibit and select levels
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            no_error_hold_n_r <= 1'b1;
            error_inhibit_ctl_n_r <= 1'b1;
            error_select_secondary_r <= 1'b0;
        end else begin
            no_error_hold_n_r <= (state_nxt != ST_HOLD);
            // inhibit stays low until the frozen latches are sent
            error_inhibit_ctl_n_r <= (state_nxt == ST_IDLE) &
                ~i_error_sense;
            if (a14y) begin
                error_select_secondary_r <= 1'b0;
            end else if (state_r != ST_IDLE && b1x &&
                (state_r == ST_HOLD || seen_a_r)) begin
                error_select_secondary_r <= 1'b1;
            end
        end
    end

    // secondary bit for phase C bit times 2..8, one per bit time
    wire [3:0] sec_idx = i_timing.bit_time - 4'h2;
    wire sec_slot = ph_c && i_timing.bit_time >= BT_2 &&
        i_timing.bit_time <= BT_8;
    wire sec_bit = sec_slot ? sec_r[sec_idx[2:0]] : 1'b0;
    // primary stream dropped while selecting secondary, except at C-1
    wire take_pri = ph_bc & ~(error_select_secondary_r & ~(ph_c & bt1));

    // secondary latch: resets at X, loads at Y
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            secondary_serial_latch_r <= 1'b0;
        end else if (i_timing.x) begin
            secondary_serial_latch_r <= 1'b0;
        end else if (i_timing.y) begin
            if (take_pri) begin
                secondary_serial_latch_r <= primary_serial_latch_r;
            end else if (error_select_secondary_r) begin
                secondary_serial_latch_r <= sec_bit;
            end
        end
    end

    // system sampler path: primary stream in B and C when enabled
    logic sds_r;
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sds_r <= 1'b0;
        end else begin
            sds_r <= primary_serial_latch_r & ph_bc & i_sds_enable &
                sds_gate;
        end
    end
    assign o_sds_out = sds_r;
    assign o_telemetry_out = secondary_serial_latch_r;

    // register decode
    wire wr_ctrl = i_wr & (i_addr == ADDR_CTRL);
    wire wr_clr = i_wr & (i_addr == ADDR_INT_CLEAR);
    wire wr_en = i_wr & (i_addr == ADDR_INT_ENABLE);
    wire sel_rise = b1x & ~error_select_secondary_r &
        (state_r == ST_HOLD || (state_r == ST_WAIT_B && seen_a_r));
    wire hold_end = (state_r == ST_HOLD) & (state_nxt == ST_IDLE);
    wire [EV_W-1:0] events = {hold_end, sel_rise, i_error_sense};

    // sticky status: a new event wins over a clear in the same cycle
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ctrl_r <= CTRL_RST;
            int_enable_r <= INT_EN_RST;
            int_status_r <= '0;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= i_wdata[1:0];
            end
            if (wr_en) begin
                int_enable_r <= i_wdata[EV_W-1:0];
            end
            int_status_r <= (int_status_r &
                ~(wr_clr ? i_wdata[EV_W-1:0] : '0)) | events;
        end
    end
    assign o_irq = |(int_status_r & int_enable_r);

    // read mux; unmapped and write-only addresses read as zero
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0;
        case (i_addr)
            ADDR_CTRL: rd_mux = {30'h0, ctrl_r};
            ADDR_INT_STATUS: rd_mux = {29'h0, int_status_r};
            ADDR_INT_ENABLE: rd_mux = {29'h0, int_enable_r};
            ADDR_STATE: rd_mux = {16'h0, pri_r, state_r,
                no_error_hold_n_r};
            ADDR_SEC_MUX: rd_mux = {22'h0, error_inhibit_ctl_n_r,
                error_select_secondary_r, error_capture_pulse_r, sec_r};
            default: rd_mux = 32'h0;
        endcase
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rdata_r <= 32'h0;
        end else begin
            rdata_r <= i_rd ? rd_mux : 32'h0;
        end
    end
    assign o_rdata = rdata_r;

endmodule

// file: test/internal_data_sampler_asserts.sv
// port-level assertion checker for the internal data sampler
`timescale 1ns/1ps
module internal_data_sampler_asserts
    import ids_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire timing_s i_timing,
    input wire logic i_sds_enable,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic o_telemetry_out,
    input wire logic o_sds_out,
    input wire logic o_irq
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);
    // bus steps that close the read data, the interrupt or the sampler output
    sequence s_no_read;
        !i_rd;
    endsequence
    sequence s_bad_read;
        i_rd && i_addr == 8'h20;
    endsequence
    sequence s_mask_all;
        i_wr && i_addr == ADDR_INT_ENABLE && i_wdata[2:0] == 3'h0;
    endsequence
    sequence s_gate_off;
        i_wr && i_addr == ADDR_CTRL && !i_wdata[1];
    endsequence
    chk_rdata_idle: assert property (s_no_read |=> o_rdata == 32'h0)
        else $error("read data not zero without a read");
    chk_unmapped_zero: assert property (s_bad_read |=> o_rdata == 32'h0)
        else $error("unmapped read returned data");
    chk_irq_masked: assert property (s_mask_all |=> !o_irq)
        else $error("interrupt high with all enables off");
    chk_sds_ctrl_gate: assert property (s_gate_off |-> ##2 !o_sds_out)
        else $error("sampler output with gate bit off");
    chk_sds_enable: assert property (!i_sds_enable |=> !o_sds_out)
        else $error("sampler output while decoder disabled");
    chk_sds_phase: assert property (
        i_timing.phase == PH_A |=> !o_sds_out)
        else $error("sampler output during phase A");
    chk_primary_clear: assert property (
        i_timing.z |-> ##2 !o_sds_out)
        else $error("primary bit not cleared at z");
    chk_tel_x_clear: assert property (
        i_timing.x |=> !o_telemetry_out)
        else $error("telemetry latch not cleared at x");
    chk_tel_a_quiet: assert property (
        i_timing.phase == PH_A && i_timing.y |=> !o_telemetry_out)
        else $error("telemetry loaded in phase A");
    // the latch may only move on its own clear or load strobe
    chk_tel_strobe_only: assert property (
        $changed(o_telemetry_out) |-> $past(i_timing.x) || $past(i_timing.y))
        else $error("telemetry moved off x and y");
endmodule

bind internal_data_sampler internal_data_sampler_asserts u_chk (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_timing(i_timing),
    .i_sds_enable(i_sds_enable), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_telemetry_out(o_telemetry_out), .o_sds_out(o_sds_out),
    .o_irq(o_irq));

// file: test/ids_far_side.sv
// far side model: timing generator plus telemetry and sampler capture
`timescale 1ns/1ps
module ids_far_side
    import ids_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_telemetry_out,
    input wire logic i_sds_out,
    output timing_s o_timing,
    output logic [14:0] o_tel_bits,
    output logic [14:0] o_sds_bits
);
    logic run_r;
    logic [1:0] sub_r;
    logic [3:0] bit_r;
    logic [1:0] ph_r;
    logic last_z;
    // strobes stay low until the counters run, so reset never fakes a w
    assign o_timing = {ph_r, bit_r, run_r && sub_r == 2'h0,
        run_r && sub_r == 2'h1, run_r && sub_r == 2'h2,
        run_r && sub_r == 2'h3};
    assign last_z = bit_r == BT_14 && sub_r == 2'h3;
    // bit time advances after z, phase after the fourteenth bit time
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            run_r <= 1'b0;
            sub_r <= 2'h0;
            bit_r <= BT_1;
            ph_r <= PH_A;
        end else if (run_r) begin
            sub_r <= sub_r + 2'h1;
            if (sub_r == 2'h3) begin
                bit_r <= last_z ? BT_1 : bit_r + 4'h1;
            end
            if (last_z) begin
                ph_r <= (ph_r == PH_C) ? PH_A : ph_r + 2'h1;
            end
        end else begin
            run_r <= 1'b1;
        end
    end
    // storage takes each bit at z, once both latches have settled
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_tel_bits <= 15'h0;
            o_sds_bits <= 15'h0;
        end else if (o_timing.z) begin
            o_tel_bits[bit_r] <= i_telemetry_out;
            o_sds_bits[bit_r] <= i_sds_out;
        end
    end
endmodule

// file: test/internal_data_sampler_tb.sv
// self-checking bench for the internal data sampler
`timescale 1ns/1ps
module internal_data_sampler_tb;
    import ids_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, sds_en = 1'b1, err = 1'b0;
    logic wr = 1'b0, rd = 1'b0, tel, sds, irq;
    logic [2:0] sel = SEL_NONE;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [SEC_W-1:0] sec = 7'h4D;
    logic [14:0] tel_bits, sds_bits;
    groups_s grp = '0;
    timing_s tim;
    int fail_count = 0;
    int checks = 0;
    always #5 clk = ~clk;
    internal_data_sampler dut (
        .i_sys_clk(clk), .i_rst_b(rst_b), .i_timing(tim),
        .i_group_sel(sel), .i_sds_enable(sds_en), .i_groups(grp),
        .i_instr_count_in(1'b0), .i_error_sense(err),
        .i_err_time_sig(13'h1E01), .i_sec_timing(sec), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .o_telemetry_out(tel), .o_sds_out(sds), .o_irq(irq));
    ids_far_side far (
        .i_sys_clk(clk), .i_rst_b(rst_b), .i_telemetry_out(tel),
        .i_sds_out(sds), .o_timing(tim), .o_tel_bits(tel_bits),
        .o_sds_bits(sds_bits));
    task automatic check(input string what, input logic [31:0] e, g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // each cycle lets one idle edge pass so no strobe is set twice at once
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
        @(posedge clk);
        #1;
    endtask
    task automatic wait_at(input logic [1:0] p, input logic [3:0] b);
        int n = 0;
        while (!(tim.phase == p && tim.bit_time == b && tim.w)) begin
            @(posedge clk);
            #1 n++;
            if (n > 400) begin
                fail_count++;
                $display("wrong value phase wait expected %0d seen none", p);
                report_and_stop();
            end
        end
    endtask
    task automatic pulse_err;
        err <= 1'b1;
        @(posedge clk);
        err <= 1'b0;
        #1;
    endtask
    task automatic t_regs;
        rd_reg(ADDR_CTRL, d);
        check("ctrl", {30'h0, CTRL_RST}, d);
        rd_reg(ADDR_INT_ENABLE, d);
        check("int_enable", {29'h0, INT_EN_RST}, d);
        rd_reg(8'h20, d);
        check("unmapped", 32'h0, d);
        wr_reg(ADDR_INT_STATUS, 32'h7);
        rd_reg(ADDR_INT_STATUS, d);
        check("int_status", 32'h0, d);
        wr_reg(ADDR_CTRL, 32'h1);
        rd_reg(ADDR_CTRL, d);
        check("ctrl write", 32'h1, d);
        wr_reg(ADDR_CTRL, 32'h3);
        rd_reg(ADDR_STATE, d);
        check("hold_n", 32'h1, {31'h0, d[0]});
        $display("test regs done");
    endtask
    // one group all ones, then all groups but that one
    task automatic t_groups;
        groups_s g;
        for (int v = 0; v < 2; v++) begin
            for (int k = 1; k <= 5; k++) begin
                g = '0;
                g[(5 - k) * PRI_W +: PRI_W] = '1;
                grp <= v ? ~g : g;
                sel <= 3'(k);
                wait_at(PH_B, BT_1);
                wait_at(PH_A, BT_1);
                check("group", 32'(v == 0), {31'h0, |sds_bits});
                check("copy", {17'h0, sds_bits}, {17'h0, tel_bits});
            end
        end
        grp <= g;
        sds_en <= 1'b0;
        wait_at(PH_B, BT_1);
        wait_at(PH_A, BT_1);
        check("sds off", 32'h0, {31'h0, |sds_bits});
        check("tel on", 32'h1, {31'h0, |tel_bits});
        sds_en <= 1'b1;
        $display("test groups done");
    endtask
    task automatic t_error_b;
        sel <= SEL_NONE;
        grp <= '0;
        wr_reg(ADDR_INT_ENABLE, 32'h7);
        wait_at(PH_B, 4'h5);
        pulse_err();
        wait_at(PH_B, 4'h7);
        rd_reg(ADDR_SEC_MUX, d);
        check("sec mux", {25'h0, sec}, {25'h0, d[6:0]});
        check("irq on", 32'h1, {31'h0, irq});
        rd_reg(ADDR_STATE, d);
        check("hold early", 32'h1, {31'h0, d[0]});
        check("err time", 32'h1E01, {19'h0, d[15:3]});
        wr_reg(ADDR_INT_CLEAR, 32'h1);
        rd_reg(ADDR_INT_STATUS, d);
        check("status clear", 32'h0, d);
        check("irq off", 32'h0, {31'h0, irq});
        wait_at(PH_A, BT_8);
        rd_reg(ADDR_STATE, d);
        check("hold in a", 32'h1, {31'h0, d[0]});
        wait_at(PH_B, BT_2);
        rd_reg(ADDR_STATE, d);
        check("hold set", 32'h0, {31'h0, d[0]});
        rd_reg(ADDR_SEC_MUX, d);
        check("select on", 32'h1, {30'h0, d[9:8]});
        rd_reg(ADDR_INT_STATUS, d);
        check("status sel", 32'h2, d);
        wait_at(PH_A, BT_1);
        check("sec stream", {25'h0, sec}, {25'h0, tel_bits[8:2]});
        wait_at(PH_B, BT_1);
        rd_reg(ADDR_SEC_MUX, d);
        check("select off", 32'h2, {30'h0, d[9:8]});
        rd_reg(ADDR_INT_STATUS, d);
        check("status end", 32'h6, d);
        wr_reg(ADDR_INT_CLEAR, 32'h7);
        $display("test error b done");
    endtask
    task automatic t_error_a;
        wr_reg(ADDR_INT_ENABLE, 32'h0);
        wait_at(PH_A, 4'h5);
        pulse_err();
        wait_at(PH_C, BT_8);
        rd_reg(ADDR_STATE, d);
        check("hold a", 32'h0, {31'h0, d[0]});
        rd_reg(ADDR_INT_STATUS, d);
        check("status", 32'h1, {31'h0, d[EV_CAPTURE]});
        check("irq masked", 32'h0, {31'h0, irq});
        wait_at(PH_A, BT_8);
        rd_reg(ADDR_STATE, d);
        check("hold third", 32'h0, {31'h0, d[0]});
        wait_at(PH_B, BT_1);
        rd_reg(ADDR_STATE, d);
        check("hold done", 32'h1, {31'h0, d[0]});
        $display("test error a done");
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        #1;
        t_regs();
        t_groups();
        t_error_b();
        t_error_a();
        report_and_stop();
    end
endmodule
